// ### timer_channel_compare_status.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module timer_channel_compare_status
  import tc_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel lines as two-way pins.
  input wire logic channel_line_a_in,
  output logic channel_line_a_out,
  output logic channel_line_a_oe,
  input wire logic channel_line_b_in,
  output logic channel_line_b_out,
  output logic channel_line_b_oe,
  // Selected external event source.
  input wire logic ext_event_in,
  // Interrupt.
  output logic irq
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] mode;
    logic [15:0] live_count;
    logic [15:0] hold_a;
    logic [15:0] hold_b;
    logic [15:0] limit_c;
    logic clk_on;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] irq_mask;
    logic a_unread;
    logic b_unread;
    logic load_b_next;
    logic line_a;
    logic line_b;
    logic prev_a;
    logic prev_ext;
    logic irq;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic pin_a_sync;
  logic pin_b_sync;
  logic ext_sync;
  logic line_a_new;
  logic line_b_new;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  sync2 u_sync_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(channel_line_a_in),
    .q(pin_a_sync)
  );

  sync2 u_sync_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(channel_line_b_in),
    .q(pin_b_sync)
  );

  sync2 u_sync_ext (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(ext_event_in),
    .q(ext_sync)
  );

  // ---------------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------------
  logic wave;
  logic wr_fire;
  logic rd_fire;
  logic sw_trig;
  logic match_a;
  logic match_b;
  logic match_c;
  logic ovf;
  logic ext_ev;
  logic a_rise;
  logic a_fall;
  logic ld_a;
  logic ld_b;
  logic [31:0] wmask;
  logic [31:0] wval;

  assign wave = s_reg.mode[MODE_WAVE];
  assign wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign rd_fire = s_axi_arvalid && !s_reg.rvalid;
  assign wmask = {{8{s_reg.w_strb[3]}}, {8{s_reg.w_strb[2]}},
                  {8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};
  assign wval = s_reg.w_data & wmask;
  assign sw_trig = wr_fire && s_reg.aw_addr == OFF_CTRL && wval[CTRL_SW_TRIG];
  assign match_a = wave && s_reg.clk_on && s_reg.live_count == s_reg.hold_a;
  assign match_b = wave && s_reg.clk_on && s_reg.live_count == s_reg.hold_b;
  assign match_c = s_reg.clk_on && s_reg.live_count == s_reg.limit_c;
  assign ovf = s_reg.clk_on && s_reg.live_count == 16'hFFFF;
  assign a_rise = pin_a_sync && !s_reg.prev_a;
  assign a_fall = !pin_a_sync && s_reg.prev_a;

  // Edge selection for the external event and the capture loads.
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    return (sel[0] && r) || (sel[1] && f);
  endfunction

  assign ext_ev = edge_hit(s_reg.mode[MODE_EXT_EDGE +: 2],
                           ext_sync && !s_reg.prev_ext, !ext_sync && s_reg.prev_ext);
  assign ld_a = !wave && s_reg.clk_on && !s_reg.load_b_next &&
                edge_hit(s_reg.mode[MODE_LOAD_A_EDGE +: 2], a_rise, a_fall);
  assign ld_b = !wave && s_reg.clk_on && s_reg.load_b_next &&
                edge_hit(s_reg.mode[MODE_LOAD_B_EDGE +: 2], a_rise, a_fall);

  // ---------------------------------------------------------------------------
  // Line action resolution
  // ---------------------------------------------------------------------------
  line_action u_act_a (
    .level(s_reg.line_a),
    .ev_match_own(match_a),
    .ev_match_c(match_c && wave),
    .ev_ext(ext_ev && wave),
    .ev_sw(sw_trig && wave),
    .act_match_own(s_reg.mode[MODE_A_MATCH_A +: 2]),
    .act_match_c(s_reg.mode[MODE_A_MATCH_C +: 2]),
    .act_ext(s_reg.mode[MODE_A_EXT +: 2]),
    .act_sw(s_reg.mode[MODE_A_SW +: 2]),
    .next_level(line_a_new)
  );

  line_action u_act_b (
    .level(s_reg.line_b),
    .ev_match_own(match_b),
    .ev_match_c(match_c && wave),
    .ev_ext(ext_ev && wave),
    .ev_sw(sw_trig && wave),
    .act_match_own(s_reg.mode[MODE_B_MATCH_B +: 2]),
    .act_match_c(s_reg.mode[MODE_B_MATCH_C +: 2]),
    .act_ext(s_reg.mode[MODE_B_EXT +: 2]),
    .act_sw(s_reg.mode[MODE_B_SW +: 2]),
    .next_level(line_b_new)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  logic [NUM_FLAGS-1:0] ev_set;
  logic [NUM_FLAGS-1:0] status_low;
  logic [NUM_FLAGS-1:0] dis_bits;
  logic [31:0] status_word;
  logic rd_status;

  // Flag events; only the hold compare, load and load overrun flags are gated by mode.
  always_comb begin
    ev_set = '0;
    ev_set[ST_OVF] = ovf;
    ev_set[ST_LOVR] = (ld_a && s_reg.a_unread) || (ld_b && s_reg.b_unread);
    ev_set[ST_CMPA] = match_a;
    ev_set[ST_CMPB] = match_b;
    ev_set[ST_CMPC] = match_c;
    ev_set[ST_LDA] = ld_a;
    ev_set[ST_LDB] = ld_b;
    ev_set[ST_ETRG] = ext_ev;
    status_low = s_reg.flags;
    status_word = '0;
    status_word[NUM_FLAGS-1:0] = status_low;
    status_word[ST_CLKON] = s_reg.clk_on;
    status_word[ST_MIRA] = wave ? s_reg.line_a : pin_a_sync;
    status_word[ST_MIRB] = wave ? s_reg.line_b : pin_b_sync;
    rd_status = rd_fire && s_axi_araddr == OFF_STATUS;
    dis_bits = wval[NUM_FLAGS-1:0];
    dis_bits[ST_LOVR] = dis_bits[ST_LOVR] && !wave;
    dis_bits[ST_LDA] = dis_bits[ST_LDA] && !wave;
    dis_bits[ST_LDB] = dis_bits[ST_LDB] && !wave;
    dis_bits[ST_CMPA] = dis_bits[ST_CMPA] && wave;
    dis_bits[ST_CMPB] = dis_bits[ST_CMPB] && wave;
  end

  always_comb begin
    s_next = s_reg;
    s_next.prev_a = pin_a_sync;
    s_next.prev_ext = ext_sync;
    // Bus handshake: address and data are taken in either order.
    if (s_axi_awvalid && !s_reg.aw_held) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_held) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    // Counter runs while its clock is on.
    if (s_reg.clk_on) begin
      s_next.live_count = s_reg.live_count + 16'h0001;
    end
    if (ld_a) begin
      s_next.hold_a = s_reg.live_count;
      s_next.a_unread = 1'b1;
      s_next.load_b_next = 1'b1;
    end
    if (ld_b) begin
      s_next.hold_b = s_reg.live_count;
      s_next.b_unread = 1'b1;
      s_next.load_b_next = 1'b0;
    end
    s_next.line_a = line_a_new;
    s_next.line_b = line_b_new;
    // Register reads.
    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = '0;
      case (s_axi_araddr)
        OFF_MODE: s_next.rdata = s_reg.mode;
        OFF_COUNT: s_next.rdata = {16'h0000, s_reg.live_count};
        OFF_HOLD_A: begin
          s_next.rdata = {16'h0000, s_reg.hold_a};
          s_next.a_unread = ld_a;
        end
        OFF_HOLD_B: begin
          s_next.rdata = {16'h0000, s_reg.hold_b};
          s_next.b_unread = ld_b;
        end
        OFF_LIMIT_C: s_next.rdata = {16'h0000, s_reg.limit_c};
        OFF_STATUS: s_next.rdata = status_word;
        OFF_IRQ_MASK: s_next.rdata = {24'h000000, s_reg.irq_mask};
        OFF_CTRL, OFF_IRQ_EN, OFF_IRQ_DIS: s_next.rdata = '0;
        default: s_next.rresp = RESP_SLVERR;
      endcase
    end
    // Sticky flags: a read clears, a same-cycle event still sets.
    s_next.flags = (rd_status ? '0 : s_reg.flags) | ev_set;
    // Register writes.
    if (wr_fire) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      case (s_reg.aw_addr)
        OFF_CTRL: begin
          if (wval[CTRL_CLK_DIS]) begin
            s_next.clk_on = 1'b0;
          end else if (wval[CTRL_CLK_EN]) begin
            s_next.clk_on = 1'b1;
          end
          if (wval[CTRL_SW_TRIG]) begin
            s_next.live_count = '0;
            s_next.clk_on = 1'b1;
          end
        end
        OFF_MODE: s_next.mode = (s_reg.mode & ~wmask) | wval;
        OFF_HOLD_A: begin
          if (wave) begin
            s_next.hold_a = s_reg.w_data[15:0];
          end
        end
        OFF_HOLD_B: begin
          if (wave) begin
            s_next.hold_b = s_reg.w_data[15:0];
          end
        end
        OFF_LIMIT_C: s_next.limit_c = s_reg.w_data[15:0];
        OFF_IRQ_EN: s_next.irq_mask = s_reg.irq_mask | wval[NUM_FLAGS-1:0];
        OFF_IRQ_DIS: s_next.irq_mask = s_reg.irq_mask & ~dis_bits;
        OFF_COUNT, OFF_STATUS, OFF_IRQ_MASK: s_next.bresp = RESP_OKAY;
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    s_next.irq = |(s_next.flags & s_next.irq_mask);
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.mode <= MODE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign s_axi_awready = !s_reg.aw_held;
  assign s_axi_wready = !s_reg.w_held;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign channel_line_a_out = s_reg.line_a;
  assign channel_line_b_out = s_reg.line_b;
  assign channel_line_a_oe = s_reg.mode[MODE_WAVE];
  assign channel_line_b_oe = s_reg.mode[MODE_WAVE];
  assign irq = s_reg.irq;

endmodule

// ### tc_pkg.sv
package tc_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_HOLD_A = 8'h14;
  localparam logic [7:0] OFF_HOLD_B = 8'h18;
  localparam logic [7:0] OFF_LIMIT_C = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN = 8'h24;
  localparam logic [7:0] OFF_IRQ_DIS = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;

  // ---------------------------------------------------------------------------
  // Control command bits
  // ---------------------------------------------------------------------------
  localparam int CTRL_CLK_EN = 0;
  localparam int CTRL_CLK_DIS = 1;
  localparam int CTRL_SW_TRIG = 2;

  // ---------------------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------------------
  localparam int MODE_WAVE = 15;
  localparam int MODE_EXT_EDGE = 8;
  localparam int MODE_LOAD_A_EDGE = 16;
  localparam int MODE_LOAD_B_EDGE = 18;
  localparam int MODE_A_MATCH_A = 16;
  localparam int MODE_A_MATCH_C = 18;
  localparam int MODE_A_EXT = 20;
  localparam int MODE_A_SW = 22;
  localparam int MODE_B_MATCH_B = 24;
  localparam int MODE_B_MATCH_C = 26;
  localparam int MODE_B_EXT = 28;
  localparam int MODE_B_SW = 30;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------------------
  localparam int ST_OVF = 0;
  localparam int ST_LOVR = 1;
  localparam int ST_CMPA = 2;
  localparam int ST_CMPB = 3;
  localparam int ST_CMPC = 4;
  localparam int ST_LDA = 5;
  localparam int ST_LDB = 6;
  localparam int ST_ETRG = 7;
  localparam int ST_CLKON = 16;
  localparam int ST_MIRA = 17;
  localparam int ST_MIRB = 18;
  localparam int NUM_FLAGS = 8;

  // Line action encoding.
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### line_action.sv
`timescale 1ns/1ps
module line_action
  import tc_pkg::*;
(
  // Current level and events.
  input wire logic level,
  input wire logic ev_match_own,
  input wire logic ev_match_c,
  input wire logic ev_ext,
  input wire logic ev_sw,
  // Action fields.
  input wire logic [1:0] act_match_own,
  input wire logic [1:0] act_match_c,
  input wire logic [1:0] act_ext,
  input wire logic [1:0] act_sw,
  // Resolved level.
  output logic next_level
);

  // Applies one action to a level.
  function automatic logic apply(input logic lv, input logic [1:0] act);
    logic r;
    r = lv;
    case (act)
      ACT_SET: r = 1'b1;
      ACT_CLEAR: r = 1'b0;
      ACT_TOGGLE: r = ~lv;
      default: r = lv;
    endcase
    return r;
  endfunction

  // Highest priority wins: software trigger, then external event, then
  // limit C match, then own hold match; only one action is applied.
  always_comb begin
    next_level = level;
    if (ev_sw && act_sw != ACT_NONE) begin
      next_level = apply(level, act_sw);
    end else if (ev_ext && act_ext != ACT_NONE) begin
      next_level = apply(level, act_ext);
    end else if (ev_match_c && act_match_c != ACT_NONE) begin
      next_level = apply(level, act_match_c);
    end else if (ev_match_own) begin
      next_level = apply(level, act_match_own);
    end
  end

endmodule

// ### sync2.sv
`timescale 1ns/1ps
module sync2 (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous level and its synchronised copy.
  input wire logic d,
  output logic q
);

  typedef struct packed {
    logic meta;
    logic q;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  // Two flops; only the second reads the first.
  always_comb begin
    s_next.meta = d;
    s_next.q = s_reg.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.q;

endmodule

// ### tc_line_partner.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Outside circuit on the two channel lines
// -----------------------------------------------------------------------------
module tc_line_partner (
  // Levels the block drives and their enables.
  input wire logic line_a_out,
  input wire logic line_a_oe,
  input wire logic line_b_out,
  input wire logic line_b_oe,
  // Levels the outside circuit applies once the block lets go.
  input wire logic drive_a,
  input wire logic drive_b,
  // Resolved wire levels fed back to the pins.
  output logic line_a_in,
  output logic line_b_in
);
  // The outside circuit drives a line only while the block has released it.
  assign line_a_in = line_a_oe ? line_a_out : drive_a;
  assign line_b_in = line_b_oe ? line_b_out : drive_b;
endmodule

// ### timer_channel_compare_status_checker.sv
`timescale 1ns/1ps
module timer_channel_compare_status_checker
  import tc_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line drive enables.
  input wire logic channel_line_a_oe,
  input wire logic channel_line_b_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // -----------------------------------------------------------------------------
  // Bus steps
  // -----------------------------------------------------------------------------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("Read answer late.");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("Write answer late.");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped before taken.");
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write answer dropped before taken.");
  a_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write answer repeated.");
  a_write_one: assert property (s_wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("Second write taken while one is held.");
  a_read_one: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rresp != 2'h1)
    else $error("Read taken while answer pending.");
  a_lines_mode: assert property ((channel_line_a_oe == channel_line_b_oe) and ($changed(channel_line_a_oe) |-> $rose(s_axi_bvalid)))
    else $error("Line enables disagree or moved without a write.");
endmodule

bind timer_channel_compare_status timer_channel_compare_status_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .channel_line_a_oe(channel_line_a_oe), .channel_line_b_oe(channel_line_b_oe));

// ### test_timer_channel_compare_status.sv
`timescale 1ns/1ps
module test_timer_channel_compare_status;
  import tc_pkg::*;
  // -----------------------------------------------------------------------------
  // Stimulus and observed signals
  // -----------------------------------------------------------------------------
  localparam logic [31:0] WV = 32'h1 << MODE_WAVE;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ext_ev = 1'b0, pa = 1'b0, pb = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_d, lf = 32'hFE6167FA;
  logic [1:0] bresp, rresp, rsp, act;
  logic awready, wready, bvalid, arready, rvalid, a_in, a_out, a_oe, b_in, b_out, b_oe, irq;
  logic ea, eb;
  logic [15:0] ha, lc, c;
  int n_fail = 0, checks = 0, n;

  always #5 aclk = ~aclk;

  timer_channel_compare_status DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .channel_line_a_in(a_in), .channel_line_a_out(a_out),
    .channel_line_a_oe(a_oe), .channel_line_b_in(b_in), .channel_line_b_out(b_out),
    .channel_line_b_oe(b_oe), .ext_event_in(ext_ev), .irq(irq));
  tc_line_partner u_far (.line_a_out(a_out), .line_a_oe(a_oe), .line_b_out(b_out),
    .line_b_oe(b_oe), .drive_a(pa), .drive_b(pb), .line_a_in(a_in), .line_b_in(b_in));

  // Step the random source and the expected line level.
  function automatic logic [31:0] next_rand();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic logic nxt(input logic l, input logic [1:0] a);
    return (a == ACT_SET) ? 1'b1 : (a == ACT_CLEAR) ? 1'b0 : (a == ACT_TOGGLE) ? ~l : l;
  endfunction

  // Compare, count and report.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Bus cycles; the slave's registered outputs are looked at mid-cycle, where they
  // already hold what the next rising edge samples, so no edge race is possible.
  // The answer is taken late on purpose so the slave must hold it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready === 1'b1;
      tw = wvalid && wready === 1'b1;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arready === 1'b1;
      @(posedge aclk);
    end while (!ta);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd_d = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Cut a hang short.
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h3C); chk(rsp, RESP_SLVERR);
    wr(8'h40, 32'h0); chk(rsp, RESP_SLVERR);
    // Software trigger with every action code on both lines.
    ea = 1'b0; eb = 1'b0;
    for (int i = 0; i < 4; i++) begin
      act = 2'(3 * (i + 1));
      wr(OFF_MODE, WV | (32'(act) << MODE_A_SW) | (32'(~act) << MODE_B_SW));
      wr(OFF_CTRL, 32'h4);
      ea = nxt(ea, act); eb = nxt(eb, ~act);
      repeat (3) @(posedge aclk);
      chk({a_oe, b_oe, a_out, b_out}, {2'b11, ea, eb});
      rd(OFF_STATUS); chk(rd_d[18:16], {eb, ea, 1'b1});
    end
    // Rising external event toggles line A and clears line B.
    wr(OFF_MODE, WV | 32'h100 | (32'(ACT_TOGGLE) << MODE_A_EXT) | (32'(ACT_CLEAR) << MODE_B_EXT));
    rd(OFF_STATUS);
    ext_ev <= 1'b1;
    repeat (6) @(posedge aclk);
    ext_ev <= 1'b0;
    chk({a_out, b_out}, {~ea, 1'b0});
    rd(OFF_STATUS); chk(rd_d[7], 1'b1);
    // Hold A sets and limit C clears line A; the gap is exactly their difference.
    ha = 16'd10 + 16'(next_rand() & 32'hF);
    lc = ha + 16'd8 + 16'(next_rand() & 32'hF);
    wr(OFF_HOLD_A, {16'hFFFF, ha});
    wr(OFF_LIMIT_C, {16'hA5A5, lc});
    wr(OFF_HOLD_B, 32'h8000);
    wr(OFF_IRQ_EN, 32'h10);
    wr(OFF_MODE, WV | (32'(ACT_CLEAR) << MODE_A_SW) | (32'(ACT_SET) << MODE_A_MATCH_A)
      | (32'(ACT_CLEAR) << MODE_A_MATCH_C));
    rd(OFF_STATUS);
    wr(OFF_CTRL, 32'h4);
    n = 0;
    // The line is watched mid-cycle so each edge that moves it is counted once.
    while (a_out !== 1'b1) @(negedge aclk);
    while (a_out !== 1'b0) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(n), 32'(lc - ha));
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    rd(OFF_HOLD_A); chk(rd_d[15:0], ha);
    rd(OFF_LIMIT_C); chk(rd_d[15:0], lc);
    rd(OFF_STATUS); chk(rd_d & 32'h700FF, 32'h00010014);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rd(OFF_STATUS); chk(rd_d[7:0], 8'h00);
    // Capture-only sources cannot be disabled while in waveform mode.
    wr(OFF_IRQ_EN, 32'h62);
    wr(OFF_IRQ_DIS, 32'hEF);
    rd(OFF_IRQ_MASK); chk(rd_d[7:0], 8'h72);
    wr(OFF_IRQ_DIS, 32'h10);
    rd(OFF_IRQ_MASK); chk(rd_d[7:0], 8'h62);
    // Disable beats enable; a stopped count stands still.
    wr(OFF_CTRL, 32'h3);
    rd(OFF_STATUS); chk(rd_d[16], 1'b0);
    rd(OFF_COUNT); c = rd_d[15:0];
    rd(OFF_COUNT); chk(rd_d[15:0], c);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_COUNT); c = rd_d[15:0];
    rd(OFF_COUNT); chk(32'(rd_d[15:0] !== c), 32'h1);
    // Capture mode: hold A refuses a write, rising edges load A then B.
    wr(OFF_MODE, (32'h1 << MODE_LOAD_A_EDGE) | (32'h1 << MODE_LOAD_B_EDGE));
    wr(OFF_HOLD_A, 32'h1234);
    rd(OFF_HOLD_A); chk(rd_d[15:0], ha);
    rd(OFF_STATUS);
    repeat (5) begin
      pa <= 1'b1;
      repeat (4) @(posedge aclk);
      pa <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    pa <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(a_oe, 1'b0);
    chk(irq, 1'b1);
    rd(OFF_STATUS); chk(rd_d & 32'h2006E, 32'h20062);
    wrap_up();
  end
endmodule
